// File: core/cfs_pkg.sv
// Constants and types for the frame statistics counter bank.
// Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
package cfs_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W  = 10;
	localparam int CNT_W  = 16;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_UP_HI     = 10'h26f;
	localparam logic [IDX_W-1:0] IDX_UP_LO     = 10'h270;
	localparam logic [IDX_W-1:0] IDX_HOST_HI   = 10'h271;
	localparam logic [IDX_W-1:0] IDX_HOST_LO   = 10'h272;
	localparam logic [IDX_W-1:0] IDX_CTRL      = 10'h280;
	localparam logic [IDX_W-1:0] IDX_UP_TRIG   = 10'h281;
	localparam logic [IDX_W-1:0] IDX_HOST_TRIG = 10'h282;

	localparam logic [7:0]       STAT_RST      = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST       = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX       = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_ONE       = 16'h0001;
	localparam logic [7:0]       CTRL_RST      = 8'h03;
	localparam int               CTRL_UP_EN    = 0;
	localparam int               CTRL_HOST_EN  = 1;
	localparam int               TRIG_SAT_BIT  = 0;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	// Frame completion events from the port logic, same clock
	typedef struct packed {
		logic upper_done;
		logic upper_ok;
		logic host_done;
	} cfs_frame_ev_s;

endpackage

// File: core/cfs_stat_regs.sv
// Saturating frame statistics counters with snapshot registers,
// reached over an AXI4-Lite slave port.
// Assumes frame events come from logic on i_core_clk, one-cycle pulses.
//
// Function
// - Count good upper-port responses, high/low bytes.
// - Upper counter saturates at all ones.
// - Upper trigger read snapshots, resets counters.
// - Count host-port transmitted responses, high/low bytes.
// - Host counter saturates at all ones.
// - Host trigger read snapshots, resets counters.
// - Host high byte read clears, resets counter.
// - Statistics bytes read-only, reset to zero.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
module cfs_stat_regs (
	input  wire logic                          i_core_clk,
	input  wire logic                          i_rst,
	input  wire cfs_pkg::cfs_frame_ev_s        i_frame_ev,
	input  wire logic [cfs_pkg::ADDR_W-1:0]    i_awaddr,
	input  wire logic                          i_awvalid,
	output logic                               o_awready,
	input  wire logic [cfs_pkg::DATA_W-1:0]    i_wdata,
	input  wire logic [3:0]                    i_wstrb,
	input  wire logic                          i_wvalid,
	output logic                               o_wready,
	output logic [1:0]                         o_bresp,
	output logic                               o_bvalid,
	input  wire logic                          i_bready,
	input  wire logic [cfs_pkg::ADDR_W-1:0]    i_araddr,
	input  wire logic                          i_arvalid,
	output logic                               o_arready,
	output logic [cfs_pkg::DATA_W-1:0]         o_rdata,
	output logic [1:0]                         o_rresp,
	output logic                               o_rvalid,
	input  wire logic                          i_rready
);

	function automatic logic [cfs_pkg::CNT_W-1:0] sat_step(
		input logic [cfs_pkg::CNT_W-1:0] v,
		input logic                      inc
	);
		return (inc && v != cfs_pkg::CNT_MAX) ? v + cfs_pkg::CNT_ONE : v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Write channel

	logic [cfs_pkg::ADDR_W-1:0] awaddr_ff;
	logic                       aw_got_ff;
	logic [7:0]                 wdata_ff;
	logic                       wstrb0_ff;
	logic                       w_got_ff;
	logic                       bvalid_ff;
	logic [1:0]                 bresp_ff;
	logic [7:0]                 ctrl_ff;

	wire aw_take = i_awvalid & o_awready;
	wire w_take  = i_wvalid & o_wready;
	wire wr_go   = aw_got_ff & w_got_ff & ~bvalid_ff;
	wire [cfs_pkg::IDX_W-1:0] wr_idx = awaddr_ff[cfs_pkg::ADDR_W-1:2];
	wire wr_align   = (awaddr_ff[1:0] == 2'b00);
	wire wr_is_ctrl = wr_align & (wr_idx == cfs_pkg::IDX_CTRL);
	wire wr_is_ro   = wr_align & ((wr_idx == cfs_pkg::IDX_UP_HI)
		| (wr_idx == cfs_pkg::IDX_UP_LO) | (wr_idx == cfs_pkg::IDX_HOST_HI)
		| (wr_idx == cfs_pkg::IDX_HOST_LO) | (wr_idx == cfs_pkg::IDX_UP_TRIG)
		| (wr_idx == cfs_pkg::IDX_HOST_TRIG));
	wire [1:0] nxt_bresp = wr_is_ctrl ? cfs_pkg::RESP_OKAY :
		wr_is_ro ? cfs_pkg::RESP_SLVERR : cfs_pkg::RESP_DECERR;
	wire       ctrl_wr   = wr_go & wr_is_ctrl & wstrb0_ff;
	wire [7:0] nxt_ctrl  = ctrl_wr ? wdata_ff : ctrl_ff;

	assign o_awready = ~aw_got_ff & ~bvalid_ff;
	assign o_wready  = ~w_got_ff & ~bvalid_ff;
	assign o_bvalid  = bvalid_ff;
	assign o_bresp   = bresp_ff;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			awaddr_ff <= '0;
			aw_got_ff <= 1'b0;
			wdata_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
			w_got_ff  <= 1'b0;
		end else begin
			if (aw_take) begin
				awaddr_ff <= i_awaddr;
			end
			if (w_take) begin
				wdata_ff  <= i_wdata[7:0];
				wstrb0_ff <= i_wstrb[0];
			end
			aw_got_ff <= wr_go ? 1'b0 : (aw_got_ff | aw_take);
			w_got_ff  <= wr_go ? 1'b0 : (w_got_ff | w_take);
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= cfs_pkg::RESP_OKAY;
			ctrl_ff   <= cfs_pkg::CTRL_RST;
		end else begin
			if (wr_go) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= nxt_bresp;
			end else if (i_bready) begin
				bvalid_ff <= 1'b0;
			end
			ctrl_ff <= nxt_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel decode and side effects

	logic                       rvalid_ff;
	logic [7:0]                 rdata_ff;
	logic [1:0]                 rresp_ff;
	logic [cfs_pkg::CNT_W-1:0]  live_up_ff;
	logic [cfs_pkg::CNT_W-1:0]  live_host_ff;
	logic [cfs_pkg::CNT_W-1:0]  snap_up_ff;
	logic [cfs_pkg::CNT_W-1:0]  snap_host_ff;

	wire rd_fire  = i_arvalid & o_arready;
	wire [cfs_pkg::IDX_W-1:0] rd_idx = i_araddr[cfs_pkg::ADDR_W-1:2];
	wire rd_ok    = rd_fire & (i_araddr[1:0] == 2'b00);
	wire rd_up_hi   = rd_ok & (rd_idx == cfs_pkg::IDX_UP_HI);
	wire rd_up_lo   = rd_ok & (rd_idx == cfs_pkg::IDX_UP_LO);
	wire rd_host_hi = rd_ok & (rd_idx == cfs_pkg::IDX_HOST_HI);
	wire rd_host_lo = rd_ok & (rd_idx == cfs_pkg::IDX_HOST_LO);
	wire rd_ctrl    = rd_ok & (rd_idx == cfs_pkg::IDX_CTRL);
	wire rd_up_trig   = rd_ok & (rd_idx == cfs_pkg::IDX_UP_TRIG);
	wire rd_host_trig = rd_ok & (rd_idx == cfs_pkg::IDX_HOST_TRIG);
	wire rd_hit = rd_up_hi | rd_up_lo | rd_host_hi | rd_host_lo | rd_ctrl
		| rd_up_trig | rd_host_trig;

	// Trigger registers report whether the live counter has saturated
	wire [7:0] up_trig_val = {7'h00, live_up_ff == cfs_pkg::CNT_MAX};
	wire [7:0] host_trig_val = {7'h00, live_host_ff == cfs_pkg::CNT_MAX};
	wire [7:0] nxt_rdata =
		rd_up_hi     ? snap_up_ff[15:8]   :
		rd_up_lo     ? snap_up_ff[7:0]    :
		rd_host_hi   ? snap_host_ff[15:8] :
		rd_host_lo   ? snap_host_ff[7:0]  :
		rd_ctrl      ? ctrl_ff            :
		rd_up_trig   ? up_trig_val        :
		rd_host_trig ? host_trig_val      : 8'h00;
	wire [1:0] nxt_rresp = rd_hit ? cfs_pkg::RESP_OKAY : cfs_pkg::RESP_DECERR;

	assign o_arready = ~rvalid_ff;
	assign o_rvalid  = rvalid_ff;
	assign o_rresp   = rresp_ff;
	assign o_rdata   = {24'h000000, rdata_ff};

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 8'h00;
			rresp_ff  <= cfs_pkg::RESP_OKAY;
		end else begin
			if (rd_fire) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= nxt_rdata;
				rresp_ff  <= nxt_rresp;
			end else if (i_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counters and snapshots

	wire up_inc   = i_frame_ev.upper_done & i_frame_ev.upper_ok
		& ctrl_ff[cfs_pkg::CTRL_UP_EN];
	wire host_inc = i_frame_ev.host_done & ctrl_ff[cfs_pkg::CTRL_HOST_EN];

	// Low byte and trigger reads restart the upper interval
	wire up_clr   = rd_up_trig | rd_up_lo;
	wire host_clr = rd_host_trig | rd_host_hi;

	wire [cfs_pkg::CNT_W-1:0] nxt_live_up =
		sat_step(up_clr ? cfs_pkg::CNT_RST : live_up_ff, up_inc);
	wire [cfs_pkg::CNT_W-1:0] nxt_live_host =
		sat_step(host_clr ? cfs_pkg::CNT_RST : live_host_ff, host_inc);

	wire [cfs_pkg::CNT_W-1:0] nxt_snap_up =
		rd_up_trig ? live_up_ff :
		rd_up_lo   ? {snap_up_ff[15:8], cfs_pkg::STAT_RST} : snap_up_ff;
	wire [cfs_pkg::CNT_W-1:0] nxt_snap_host =
		rd_host_trig ? live_host_ff :
		rd_host_hi   ? {cfs_pkg::STAT_RST, snap_host_ff[7:0]} : snap_host_ff;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			live_up_ff   <= cfs_pkg::CNT_RST;
			live_host_ff <= cfs_pkg::CNT_RST;
			snap_up_ff   <= cfs_pkg::CNT_RST;
			snap_host_ff <= cfs_pkg::CNT_RST;
		end else begin
			live_up_ff   <= nxt_live_up;
			live_host_ff <= nxt_live_host;
			snap_up_ff   <= nxt_snap_up;
			snap_host_ff <= nxt_snap_host;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	up_sat_hold_a: assert property (
		live_up_ff == cfs_pkg::CNT_MAX && !up_clr
		|=> live_up_ff == cfs_pkg::CNT_MAX)
		else $error("upper counter left saturation");

	host_sat_hold_a: assert property (
		live_host_ff == cfs_pkg::CNT_MAX && !host_clr
		|=> live_host_ff == cfs_pkg::CNT_MAX)
		else $error("host counter left saturation");

	up_count_one_a: assert property (
		up_inc && !up_clr && live_up_ff != cfs_pkg::CNT_MAX
		|=> live_up_ff == $past(live_up_ff) + cfs_pkg::CNT_ONE)
		else $error("upper counter did not step by one");

	host_count_one_a: assert property (
		host_inc && !host_clr && live_host_ff != cfs_pkg::CNT_MAX
		|=> live_host_ff == $past(live_host_ff) + cfs_pkg::CNT_ONE)
		else $error("host counter did not step by one");

	bad_frame_ignored_a: assert property (
		i_frame_ev.upper_done && !i_frame_ev.upper_ok && !up_clr
		|=> $stable(live_up_ff))
		else $error("invalid frame changed upper count");

	up_snapshot_a: assert property (
		rd_up_trig |=> snap_up_ff == $past(live_up_ff)
		&& live_up_ff == {15'h0000, $past(up_inc)}
		&& o_rvalid && o_rdata[7:0] == $past(up_trig_val))
		else $error("upper snapshot wrong");

	host_snapshot_a: assert property (
		rd_host_trig |=> snap_host_ff == $past(live_host_ff)
		&& live_host_ff == {15'h0000, $past(host_inc)})
		else $error("host snapshot wrong");

	host_hi_clear_a: assert property (
		rd_host_hi |=> snap_host_ff[15:8] == 8'h00
		&& o_rdata[7:0] == $past(snap_host_ff[15:8])
		&& live_host_ff == {15'h0000, $past(host_inc)})
		else $error("host high byte not cleared on read");

	ro_write_err_a: assert property (
		wr_go && wr_is_ro |=> o_bvalid && o_bresp == cfs_pkg::RESP_SLVERR
		&& $stable(snap_up_ff) && $stable(snap_host_ff))
		else $error("write to statistics not refused");

	up_lo_clear_a: assert property (
		rd_up_lo |=> snap_up_ff[7:0] == 8'h00
		&& o_rdata[7:0] == $past(snap_up_ff[7:0])
		&& live_up_ff == {15'h0000, $past(up_inc)})
		else $error("upper low byte not cleared on read");

	up_snap_quiet_a: assert property (
		!rd_up_trig && !rd_up_lo |=> $stable(snap_up_ff))
		else $error("upper snapshot changed without a read");

	host_snap_quiet_a: assert property (
		!rd_host_trig && !rd_host_hi |=> $stable(snap_host_ff))
		else $error("host snapshot changed without a read");

	up_idle_a: assert property (
		!up_inc && !up_clr |=> $stable(live_up_ff))
		else $error("upper counter moved without a frame");

	host_idle_a: assert property (
		!host_inc && !host_clr |=> $stable(live_host_ff))
		else $error("host counter moved without a frame");

	////////////////////////////////////////////////////////////////////////
	// Register bus handshake checks

	write_answer_a: assert property (
		wr_go |=> o_bvalid)
		else $error("write response missing");

	bresp_hold_a: assert property (
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped early");

	bvalid_drop_a: assert property (
		o_bvalid && i_bready |=> !o_bvalid)
		else $error("write response not released");

	read_answer_a: assert property (
		rd_fire |=> o_rvalid)
		else $error("read answer missing");

	read_hold_a: assert property (
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)
		&& $stable(o_rresp))
		else $error("read answer dropped early");

	unmapped_read_a: assert property (
		rd_fire && !rd_hit |=> o_rresp == cfs_pkg::RESP_DECERR
		&& o_rdata == 32'h00000000)
		else $error("unmapped read not refused");

	ctrl_write_a: assert property (
		ctrl_wr |=> ctrl_ff == $past(wdata_ff))
		else $error("control write lost");

	up_snap_cover_c: cover property (rd_up_trig ##1 snap_up_ff != 16'h0000);
	host_snap_cover_c: cover property (rd_host_trig ##1 o_rvalid);
	host_hi_cover_c: cover property (rd_host_hi && snap_host_ff[15:8] != 8'h00);
	up_sat_cover_c: cover property (
		live_up_ff == cfs_pkg::CNT_MAX && up_inc);
	ro_write_cover_c: cover property (wr_go && wr_is_ro);

endmodule

// File: test/cfs_tb.sv
// Self-checking bench for the frame statistics counter bank.
// Assumes cfs_stat_regs with assertions inside; drives AXI4-Lite and events.
`timescale 1ns/100ps
module tb;
	logic                  clk;
	logic                  rst;
	cfs_pkg::cfs_frame_ev_s ev;
	logic [11:0]           awaddr;
	logic                  awvalid;
	logic                  awready;
	logic [31:0]           wdata;
	logic                  wvalid;
	logic                  wready;
	logic [1:0]            bresp;
	logic                  bvalid;
	logic                  bready;
	logic [11:0]           araddr;
	logic                  arvalid;
	logic                  arready;
	logic [31:0]           rdata;
	logic [1:0]            rresp;
	logic                  rvalid;
	logic                  rready;
	logic [31:0]           rd_d;
	logic [1:0]            rsp;
	int                    err_count;
	int                    checks;
	int                    cyc;

	cfs_stat_regs i_dut (.i_core_clk(clk), .i_rst(rst), .i_frame_ev(ev),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready));

	always #2 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rd_d = rdata;
		rsp  = rresp;
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		rd(a);
		chk(nm, e, rd_d);
		chk({nm, " resp"}, {30'h0, cfs_pkg::RESP_OKAY}, {30'h0, rsp});
	endtask

	task automatic pulse(input logic [2:0] v, input int n);
		@(posedge clk);
		ev <= v;
		repeat (n) @(posedge clk);
		ev <= 3'h0;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_chk("up_hi", 12'h9bc, 32'h0);
		rd_chk("up_lo", 12'h9c0, 32'h0);
		rd_chk("host_hi", 12'h9c4, 32'h0);
		rd_chk("host_lo", 12'h9c8, 32'h0);
		wr(12'h9bc, 32'h5a);
		chk("wr_ro", {30'h0, cfs_pkg::RESP_SLVERR}, {30'h0, rsp});
		rd_chk("up_hi_kept", 12'h9bc, 32'h0);
		rd(12'ha10);
		chk("unmapped", {30'h0, cfs_pkg::RESP_DECERR}, {30'h0, rsp});
		chk("unmapped_data", 32'h0, rd_d);
	endtask

	task automatic t_upper();
		pulse(3'b110, 3);
		pulse(3'b100, 2);
		rd_chk("up_trig", 12'ha04, 32'h0);
		rd_chk("up_hi", 12'h9bc, 32'h0);
		rd_chk("up_lo", 12'h9c0, 32'h3);
		rd_chk("up_lo_clr", 12'h9c0, 32'h0);
		rd(12'ha04);
		rd_chk("up_lo_reset", 12'h9c0, 32'h0);
	endtask

	task automatic t_host();
		wr(12'ha00, 32'h1);
		chk("ctrl_resp", 32'h0, {30'h0, rsp});
		pulse(3'b001, 4);
		wr(12'ha00, 32'h3);
		rd_chk("ctrl", 12'ha00, 32'h3);
		pulse(3'b001, 2);
		rd(12'ha08);
		rd_chk("host_lo", 12'h9c8, 32'h2);
		rd_chk("host_hi", 12'h9c4, 32'h0);
	endtask

	task automatic t_sat();
		pulse(3'b111, 65540);
		rd_chk("up_trig_sat", 12'ha04, 32'h1);
		rd_chk("host_trig_sat", 12'ha08, 32'h1);
		rd_chk("up_hi_sat", 12'h9bc, 32'hff);
		rd_chk("up_lo_sat", 12'h9c0, 32'hff);
		rd_chk("host_lo_sat", 12'h9c8, 32'hff);
		rd_chk("host_hi_sat", 12'h9c4, 32'hff);
		rd_chk("host_hi_clr", 12'h9c4, 32'h0);
		rd_chk("host_lo_kept", 12'h9c8, 32'hff);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		clk = 1'b0; rst = 1'b1; ev = 3'h0; cyc = 0;
		awaddr = 12'h0; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0;
		bready = 1'b0; araddr = 12'h0; arvalid = 1'b0; rready = 1'b0;
		err_count = 0; checks = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_upper();
		t_host();
		t_sat();
		summarize();
	end
endmodule
